// *** design/ext_bus_cfg.svh ***
// Constants for the external memory bus controller.
`ifndef EXT_BUS_CFG_SVH
`define EXT_BUS_CFG_SVH
`define ADDR_W 20
`define DATA_W 16
`define CS_COUNT 4
`define WAIT_RESET 4'h0
`define STROBE_MIN 4'h2
`endif

// *** design/ext_bus_pkg.sv ***
// Types for the external memory bus controller.
package ext_bus_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_DATA = 3'b010,
      ST_WAIT = 3'b011,
      ST_DONE = 3'b100,
      ST_HOLD = 3'b101
   } bus_state_e;
endpackage

// *** design/external_memory_bus_control.sv ***
// External memory bus controller: address, data, strobes, chip selects, hold and wait.
//
// Overview of operation
// - Reset pin held low keeps the whole block in its reset state.
// - Mode strap low after reset gives single-chip mode, high gives microprocessor mode.
// - Width select low gives a 16-bit data bus, high gives 8 bits.
// - Separate bus: low lines carry bits 0-7, upper lines 8-15 only at 16 bits.
// - A 20-line address output carries address bits 0 to 19.
// - Multiplexed 8-bit: address bits 0-7 share lines with data bits 0-7.
// - Multiplexed 16-bit: address bits 1-8 share lines with data bits 0-7.
// - Four low-active chip selects, each for its own external space.
// - A software setting picks split write strobes or single strobe plus byte enable.
// - Split scheme: low-byte write strobe low on writes to even addresses.
// - Split scheme: high-byte write strobe low on writes to odd addresses.
// - Read strobe low while data is read, in either scheme.
// - Single scheme: write strobe low on any write, whatever the parity.
// - Single scheme: high-byte enable low for an odd address in the data phase, and in the address phase only when multiplexed.
// - An 8-bit bus must use the single strobe scheme.
// - An address latch strobe lets outside logic capture the address.
// - Hold input low requests the bus; hold lasts while it stays low.
// - Hold acknowledge is low in hold and high otherwise.
// - Ready input low stretches an access; wait lasts while it is low.
`timescale 1ns/10ps
`include "ext_bus_cfg.svh"
module external_memory_bus_control
   import ext_bus_pkg::*;
(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic reset_n_in,
   input wire logic processor_mode_strap_in,
   input wire logic bus_width_8_in,
   input wire logic multiplex_in,
   input wire logic single_strobe_sel_in,
   input wire logic hold_n_in,
   input wire logic ready_n_in,
   input wire logic req_valid_in,
   input wire logic req_write_in,
   input wire logic [`ADDR_W-1:0] req_addr_in,
   input wire logic [`DATA_W-1:0] req_wdata_in,
   input wire logic [1:0] req_cs_in,
   input wire logic [`DATA_W-1:0] data_lines_in,
   output logic [`ADDR_W-1:0] address_lines_out,
   output logic address_lines_oe_n_out,
   output logic [`DATA_W-1:0] data_lines_out,
   output logic [1:0] data_lines_oe_n_out,
   output logic [`CS_COUNT-1:0] chip_select_lines_n_out,
   output logic read_strobe_n_out,
   output logic write_strobe_low_byte_n_out,
   output logic write_strobe_high_byte_n_out,
   output logic strobe_oe_n_out,
   output logic address_latch_out,
   output logic hold_acknowledge_n_out,
   output logic microprocessor_mode_out,
   output logic in_reset_out,
   output logic req_ready_out,
   output logic resp_valid_out,
   output logic [`DATA_W-1:0] resp_rdata_out
);

   typedef struct packed {
      logic [1:0] rst_sync;
      logic [1:0] hold_sync;
      logic [1:0] rdy_sync;
      logic [1:0] mode_sync;
      logic [1:0] width_sync;
      logic [1:0] mux_sync;
      logic [1:0] strb_sync;
      bus_state_e state;
      logic in_reset;
      logic up_mode;
      logic wr;
      logic [`ADDR_W-1:0] addr;
      logic [`DATA_W-1:0] wdata;
      logic [1:0] cs;
      logic [`ADDR_W-1:0] a_out;
      logic a_oe_n;
      logic [`DATA_W-1:0] d_out;
      logic [1:0] d_oe_n;
      logic [`CS_COUNT-1:0] cs_n;
      logic rd_n;
      logic wrl_n;
      logic wrh_n;
      logic s_oe_n;
      logic ale;
      logic hold_acknowledge_n;
      logic req_ready;
      logic resp_valid;
      logic [`DATA_W-1:0] rdata;
      logic [`DATA_W-1:0] data_meta;
      logic [`DATA_W-1:0] data_sync;
      logic [3:0] strobe_cnt;
   } ctl_s;

   ctl_s r;
   ctl_s next_r;

   // Decodes a two-bit space number into four low-active selects.
   function automatic logic [`CS_COUNT-1:0] cs_decode(input logic [1:0] sel);
      logic [`CS_COUNT-1:0] v;
      v = {`CS_COUNT{1'b1}};
      v[sel] = 1'b0;
      return v;
   endfunction

   // Effective configuration from the synchronised pins.
   logic cfg_8bit;
   logic cfg_mux;
   logic cfg_single;
   assign cfg_8bit = r.width_sync[1];
   assign cfg_mux = r.mux_sync[1];
   // An 8-bit bus forces the single strobe scheme whatever software asked for.
   assign cfg_single = r.strb_sync[1] | cfg_8bit;

   // Next-state logic; strobes are recomputed every cycle from the held access.
   always_comb begin
      next_r = r;
      next_r.rst_sync = {r.rst_sync[0], reset_n_in};
      next_r.hold_sync = {r.hold_sync[0], hold_n_in};
      next_r.rdy_sync = {r.rdy_sync[0], ready_n_in};
      next_r.mode_sync = {r.mode_sync[0], processor_mode_strap_in};
      next_r.width_sync = {r.width_sync[0], bus_width_8_in};
      next_r.mux_sync = {r.mux_sync[0], multiplex_in};
      next_r.strb_sync = {r.strb_sync[0], single_strobe_sel_in};
      // Data pins pass two stages like every other pin before any logic reads them.
      next_r.data_meta = data_lines_in;
      next_r.data_sync = r.data_meta;
      next_r.resp_valid = 1'b0;
      next_r.req_ready = 1'b0;
      next_r.ale = 1'b0;
      next_r.rd_n = 1'b1;
      next_r.wrl_n = 1'b1;
      next_r.wrh_n = 1'b1;
      next_r.cs_n = {`CS_COUNT{1'b1}};
      next_r.d_oe_n = 2'b11;
      next_r.a_oe_n = 1'b0;
      next_r.s_oe_n = 1'b0;
      next_r.hold_acknowledge_n = 1'b1;
      if (!r.rst_sync[1]) begin
         // Pin reset holds everything idle; the strap is sampled on release.
         next_r.in_reset = 1'b1;
         next_r.state = ST_IDLE;
      end else begin
         next_r.in_reset = 1'b0;
         if (r.in_reset) begin
            next_r.up_mode = r.mode_sync[1];
         end
         case (r.state)
            ST_IDLE: begin
               if (!r.hold_sync[1]) begin
                  next_r.state = ST_HOLD;
               end else if (r.up_mode && !r.in_reset) begin
                  // Ready is withheld when hold or pin reset reaches the second stage
                  // next edge, so a request is never offered on an edge that leaves idle.
                  next_r.req_ready = next_r.hold_sync[1] & next_r.rst_sync[1];
                  if (req_valid_in && r.req_ready) begin
                     next_r.req_ready = 1'b0;
                     next_r.wr = req_write_in;
                     next_r.addr = req_addr_in;
                     next_r.wdata = req_wdata_in;
                     next_r.cs = req_cs_in;
                     next_r.state = ST_ADDR;
                  end
               end
            end
            ST_ADDR: begin
               next_r.strobe_cnt = `WAIT_RESET;
               next_r.state = ST_DATA;
            end
            ST_DATA, ST_WAIT: begin
               // Data pins pass two flip-flops, so the strobe stands for a minimum span
               // before the synchronised read data can be trusted; this costs two cycles.
               if (r.strobe_cnt != `STROBE_MIN) begin
                  next_r.strobe_cnt = r.strobe_cnt + 4'h1;
               end
               // Ready low keeps the strobes active and stretches the access.
               if (!r.rdy_sync[1] || r.strobe_cnt != `STROBE_MIN) begin
                  next_r.state = ST_WAIT;
               end else begin
                  // Read data is taken while the read strobe is still low.
                  if (!r.wr) begin
                     next_r.rdata = cfg_8bit ? {8'h00, r.data_sync[7:0]} : r.data_sync;
                  end
                  next_r.state = ST_DONE;
               end
            end
            ST_DONE: begin
               next_r.resp_valid = !r.wr;
               next_r.state = ST_IDLE;
            end
            ST_HOLD: begin
               if (r.hold_sync[1]) begin
                  next_r.state = ST_IDLE;
               end
            end
            default: begin
               next_r.state = ST_IDLE;
            end
         endcase
         // Output drive for the state being entered.
         case (next_r.state)
            ST_ADDR, ST_DATA, ST_WAIT: begin
               next_r.a_out = next_r.addr;
               next_r.cs_n = cs_decode(next_r.cs);
               next_r.ale = (next_r.state == ST_ADDR);
               if (next_r.state != ST_ADDR) begin
                  if (next_r.wr) begin
                     if (cfg_single) begin
                        next_r.wrl_n = 1'b0;
                        next_r.wrh_n = !next_r.addr[0];
                     end else begin
                        next_r.wrl_n = next_r.addr[0];
                        next_r.wrh_n = !next_r.addr[0];
                     end
                     next_r.d_oe_n = cfg_8bit ? 2'b10 : 2'b00;
                     next_r.d_out = next_r.wdata;
                  end else begin
                     next_r.rd_n = 1'b0;
                     if (cfg_single) begin
                        next_r.wrh_n = !next_r.addr[0];
                     end
                  end
               end else if (cfg_mux) begin
                  // Address phase of a multiplexed cycle drives the shared lines.
                  next_r.d_oe_n[0] = 1'b0;
                  next_r.d_out[7:0] = cfg_8bit ? next_r.addr[7:0]
                                               : next_r.addr[8:1];
                  if (cfg_single) begin
                     next_r.wrh_n = !next_r.addr[0];
                  end
               end
            end
            ST_HOLD: begin
               // Release the bus so the outside master can drive it.
               next_r.hold_acknowledge_n = 1'b0;
               next_r.a_oe_n = 1'b1;
               next_r.s_oe_n = 1'b1;
               next_r.d_oe_n = 2'b11;
            end
            default: begin
            end
         endcase
      end
   end

   // Single register stage for all state; synchronous reset to safe levels.
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         r <= '0;
         r.rst_sync <= 2'b00;
         r.hold_sync <= 2'b11;
         r.rdy_sync <= 2'b11;
         r.state <= ST_IDLE;
         r.in_reset <= 1'b1;
         r.d_oe_n <= 2'b11;
         r.cs_n <= {`CS_COUNT{1'b1}};
         r.rd_n <= 1'b1;
         r.wrl_n <= 1'b1;
         r.wrh_n <= 1'b1;
         r.hold_acknowledge_n <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign address_lines_out = r.a_out;
   assign address_lines_oe_n_out = r.a_oe_n;
   assign data_lines_out = r.d_out;
   assign data_lines_oe_n_out = r.d_oe_n;
   assign chip_select_lines_n_out = r.cs_n;
   assign read_strobe_n_out = r.rd_n;
   assign write_strobe_low_byte_n_out = r.wrl_n;
   assign write_strobe_high_byte_n_out = r.wrh_n;
   assign strobe_oe_n_out = r.s_oe_n;
   assign address_latch_out = r.ale;
   assign hold_acknowledge_n_out = r.hold_acknowledge_n;
   assign microprocessor_mode_out = r.up_mode;
   assign in_reset_out = r.in_reset;
   assign req_ready_out = r.req_ready;
   assign resp_valid_out = r.resp_valid;
   assign resp_rdata_out = r.rdata;

   // Checks on the bus sequencing.
   hold_ack_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (r.state == ST_HOLD) |-> !r.hold_acknowledge_n) else $error("hold ack not low in hold");
   hold_idle_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (r.state != ST_HOLD) |-> r.hold_acknowledge_n) else $error("hold ack low outside hold");
   hold_release_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      !r.hold_acknowledge_n |-> r.a_oe_n && r.s_oe_n && r.d_oe_n == 2'b11)
      else $error("bus not released in hold");
   hold_enter_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (r.state == ST_IDLE && r.rst_sync[1] && !r.hold_sync[1]) |=> !r.hold_acknowledge_n)
      else $error("hold not entered");
   reset_hold_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      !r.rst_sync[1] |=> r.in_reset && r.state == ST_IDLE)
      else $error("reset pin not obeyed");
   mode_latch_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (r.in_reset && r.rst_sync[1]) |=> r.up_mode == $past(r.mode_sync[1]))
      else $error("mode strap not latched");
   strobe_excl_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      !r.rd_n |-> r.wrl_n && r.cs_n != 4'hf) else $error("read with write or no cs");
   read_strobe_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (!r.wr && (r.state == ST_DATA || r.state == ST_WAIT)) |-> !r.rd_n)
      else $error("read strobe not low");
   split_parity_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (!cfg_single && r.wr && r.state == ST_DATA)
      |-> r.wrl_n == r.addr[0] && r.wrh_n == !r.addr[0])
      else $error("split strobe parity wrong");
   single_wr_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (cfg_single && r.wr && r.state == ST_DATA) |-> !r.wrl_n)
      else $error("single write strobe not low");
   byte_enable_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (cfg_single && r.state == ST_DATA) |-> r.wrh_n == !r.addr[0])
      else $error("byte enable parity wrong");
   byte_single_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (cfg_8bit && r.wr && r.state == ST_DATA) |-> !r.wrl_n)
      else $error("byte bus not on single strobe");
   lane_drive_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (r.wr && r.state == ST_DATA) |-> r.d_oe_n == (cfg_8bit ? 2'b10 : 2'b00))
      else $error("write byte lanes wrong");
   wait_stretch_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (r.state == ST_DATA && !r.rdy_sync[1]) |=> r.state == ST_WAIT)
      else $error("ready low did not stretch");
   wait_hold_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (r.state == ST_WAIT && !r.rdy_sync[1]) |=> r.state == ST_WAIT)
      else $error("wait left while ready low");
   ale_phase_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      r.ale |=> r.state == ST_DATA || r.state == ST_WAIT)
      else $error("latch strobe out of phase");
   addr_drive_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      r.ale |-> r.a_out == r.addr && !r.a_oe_n) else $error("address not driven");
   mux_addr_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (r.ale && cfg_mux) |-> !r.d_oe_n[0]
      && r.d_out[7:0] == (cfg_8bit ? r.addr[7:0] : r.addr[8:1]))
      else $error("multiplexed address wrong");
   cs_one_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      r.state == ST_DATA |-> $countones(~r.cs_n) == 1) else $error("chip select count");

   read_c: cover property (@(posedge clock_in) r.resp_valid);
   write_c: cover property (@(posedge clock_in) r.state == ST_DATA && r.wr);
   wait_c: cover property (@(posedge clock_in) r.state == ST_WAIT);
   hold_c: cover property (@(posedge clock_in) !r.hold_acknowledge_n);
   mux_c: cover property (@(posedge clock_in) r.ale && !r.d_oe_n[0]);

endmodule

// *** tb/ext_mem_model.sv ***
// Behavioural external memory that answers reads and can stretch them.
`timescale 1ns/10ps
module ext_mem_model (
   input wire logic clock_in,
   input wire logic slow_in,
   input wire logic [19:0] addr_in,
   input wire logic ale_in,
   input wire logic rd_n_in,
   output logic [15:0] data_out,
   output logic ready_n_out
);
   logic [19:0] addr_lat = 20'h0;
   logic [15:0] last = 16'h0;
   logic [3:0] cnt = 4'h0;
   logic [15:0] word;

   // Outside glue captures the address on the latch strobe; read data follows from it.
   always @(posedge clock_in) begin
      if (ale_in) begin
         addr_lat <= addr_in;
      end
      if (!rd_n_in) begin
         last <= word;
      end
      cnt <= rd_n_in ? 4'h0 : cnt + 4'h1;
   end

   // A released bus shows the inverse of the last value, so stale data cannot pass.
   assign word = {addr_lat[7:0] ^ 8'ha5, addr_lat[7:0]};
   assign data_out = rd_n_in ? ~last : word;
   // Ready is synchronised inside the device, so the stretch starts before the strobe.
   assign ready_n_out = !(slow_in && (cnt < 4'h3));
endmodule

// *** tb/external_memory_bus_control_tb_top.sv ***
// Self-checking testbench for the external memory bus controller.
`timescale 1ns/10ps
module external_memory_bus_control_tb_top;
   logic clock_in, sys_rst_in, reset_n_in, strap, w8, mux, single, hold_n, ready_n, slow;
   logic req_valid, req_write;
   logic [19:0] req_addr, a_out, ale_addr;
   logic [15:0] req_wdata, d_in, d_out, rdata, r, wr_data;
   logic [1:0] req_cs, d_oe_n, wr_oe;
   logic [3:0] cs_n, cs_seen;
   logic rd_n, wl_n, wh_n, a_oe_n, s_oe_n, ale, hold_acknowledge_n, up_mode, in_rst, rdy, rv;
   logic rd_seen, wl_seen, wh_seen;
   logic [7:0] ale_mux;
   int failures = 0;
   int checked = 0;
   int l;

   external_memory_bus_control u_external_memory_bus_control (.clock_in(clock_in),
      .sys_rst_in(sys_rst_in), .reset_n_in(reset_n_in), .processor_mode_strap_in(strap),
      .bus_width_8_in(w8), .multiplex_in(mux), .single_strobe_sel_in(single),
      .hold_n_in(hold_n), .ready_n_in(ready_n), .req_valid_in(req_valid),
      .req_write_in(req_write), .req_addr_in(req_addr), .req_wdata_in(req_wdata),
      .req_cs_in(req_cs), .data_lines_in(d_in), .address_lines_out(a_out),
      .address_lines_oe_n_out(a_oe_n), .data_lines_out(d_out), .data_lines_oe_n_out(d_oe_n),
      .chip_select_lines_n_out(cs_n), .read_strobe_n_out(rd_n),
      .write_strobe_low_byte_n_out(wl_n), .write_strobe_high_byte_n_out(wh_n),
      .strobe_oe_n_out(s_oe_n), .address_latch_out(ale), .hold_acknowledge_n_out(hold_acknowledge_n),
      .microprocessor_mode_out(up_mode), .in_reset_out(in_rst), .req_ready_out(rdy),
      .resp_valid_out(rv), .resp_rdata_out(rdata));

   ext_mem_model u_ext_mem_model (.clock_in(clock_in), .slow_in(slow), .addr_in(a_out),
      .ale_in(ale), .rd_n_in(rd_n), .data_out(d_in), .ready_n_out(ready_n));

   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end

   // Record every strobe seen low during an access, at the settled half of the cycle.
   always @(negedge clock_in) begin
      cs_seen = cs_seen | ~cs_n;
      rd_seen = rd_seen | ~rd_n;
      wl_seen = wl_seen | ~wl_n;
      wh_seen = wh_seen | ~wh_n;
      if (ale) begin
         ale_addr = a_out;
         ale_mux = d_out[7:0];
      end
      // Lanes driven in the data phase show which byte lanes carry write data.
      if (!ale && d_oe_n != 2'b11) begin
         wr_oe = d_oe_n;
         wr_data = d_out;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask

   task automatic conclude;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // One access; called just after a rising edge, holds the request until it is taken.
   task automatic access(input logic w, input logic [19:0] a, input logic [1:0] c);
      int n;
      {cs_seen, rd_seen, wl_seen, wh_seen} = 7'h0;
      wr_oe = 2'b11;
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= 16'h5a3c;
      req_cs <= c;
      n = 0;
      do begin
         @(posedge clock_in);
         n++;
      end while (rdy !== 1'b1 && n < 50);
      req_valid <= 1'b0;
      l = 0;
      do begin
         @(negedge clock_in);
         l++;
      end while (rv !== 1'b1 && l < 40 && !(w && l == 6));
      r = rdata;
      repeat (3) @(posedge clock_in);
   endtask

   task automatic cfg(input logic b8, input logic m, input logic s);
      w8 <= b8;
      mux <= m;
      single <= s;
      repeat (4) @(posedge clock_in);
   endtask

   task automatic boot(input logic s);
      reset_n_in <= 1'b0;
      strap <= s;
      repeat (5) @(posedge clock_in);
      chk({in_rst, rdy}, 2'b10, "held in reset");
      reset_n_in <= 1'b1;
      repeat (8) @(posedge clock_in);
      chk({in_rst, up_mode, rdy}, {1'b0, s, s}, "start mode");
   endtask

   initial begin
      {strap, w8, mux, single, slow, req_valid, req_write} = 7'h0;
      {req_addr, req_wdata, req_cs} = 38'h0;
      {reset_n_in, hold_n, sys_rst_in} = 3'b111;
      repeat (2) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      @(posedge clock_in);
      chk({in_rst, hold_acknowledge_n}, 2'b11, "after reset");
      boot(1'b0);
      boot(1'b1);
      cfg(1'b0, 1'b0, 1'b0);
      access(1'b1, 20'hab124, 2'h2);
      chk({cs_seen, wl_seen, wh_seen, rd_seen}, 7'b0100100, "even write");
      chk(ale_addr, 20'hab124, "address out");
      chk({wr_oe, wr_data}, {2'b00, 16'h5a3c}, "word write lanes");
      access(1'b1, 20'h04567, 2'h3);
      chk({cs_seen, wl_seen, wh_seen, rd_seen}, 7'b1000010, "odd write");
      access(1'b0, 20'h30a42, 2'h0);
      chk({cs_seen, wl_seen, wh_seen, rd_seen}, 7'b0001001, "read strobes");
      // Data passes two pin stages, so a plain read answers six cycles after it is taken.
      chk({r, l[7:0]}, {8'he7, 8'h42, 8'h06}, "read word");
      cfg(1'b0, 1'b0, 1'b1);
      access(1'b1, 20'h00010, 2'h1);
      chk({wl_seen, wh_seen, rd_seen}, 3'b100, "single even write");
      access(1'b1, 20'h00011, 2'h1);
      chk({wl_seen, wh_seen}, 2'b11, "single odd write");
      cfg(1'b1, 1'b0, 1'b0);
      access(1'b1, 20'h00031, 2'h0);
      chk({wl_seen, wh_seen}, 2'b11, "byte bus strobes");
      chk({wr_oe, wr_data[7:0]}, {2'b10, 8'h3c}, "byte write lanes");
      access(1'b0, 20'h000c3, 2'h0);
      chk(r, 16'h00c3, "byte bus read");
      cfg(1'b1, 1'b1, 1'b1);
      access(1'b1, 20'h000a7, 2'h0);
      chk(ale_mux, 8'ha7, "mux byte address");
      cfg(1'b0, 1'b1, 1'b0);
      access(1'b1, 20'h001a6, 2'h0);
      chk(ale_mux, 8'hd3, "mux word address");
      cfg(1'b0, 1'b0, 1'b0);
      slow <= 1'b1;
      access(1'b0, 20'h00055, 2'h0);
      chk(l > 6 && l < 12, 1, "stretched read");
      chk(r, 16'hf055, "stretched data");
      slow <= 1'b0;
      hold_n <= 1'b0;
      repeat (6) @(posedge clock_in);
      chk({hold_acknowledge_n, a_oe_n, s_oe_n, d_oe_n, rdy}, 6'b011110, "hold entry");
      repeat (8) @(posedge clock_in);
      chk(hold_acknowledge_n, 1'b0, "hold kept");
      hold_n <= 1'b1;
      repeat (6) @(posedge clock_in);
      chk({hold_acknowledge_n, rdy}, 2'b11, "hold left");
      conclude();
   end

   // A hang would otherwise stall the run; the tests need well under 10 microseconds.
   initial begin
      #100000;
      failures++;
      conclude();
   end
endmodule
